// file: design/ssc_pkg.sv
// Package with constants for the sensor SPI configuration slave
package ssc_pkg;
  localparam int SSC_ADDR_W = 7;
  localparam int SSC_DATA_W = 8;
  localparam int SSC_BANK_W = 2;
  localparam int SSC_NBANK = 4;
  localparam int SSC_NREG = 128;
  localparam logic [6:0] SSC_ADDR_BANK = 7'h00;
  localparam logic [6:0] SSC_ADDR_SOFT = 7'h03;
  localparam int SSC_SOFT_BIT = 0;
  localparam logic [7:0] SSC_REG_RST = 8'h00;
  localparam logic [3:0] SSC_HDR_BITS = 4'h8;
  localparam logic [2:0] SSC_LAST_BIT = 3'h7;
  localparam logic [2:0] SSC_PLL_BIT = 3'h0;
  localparam logic [6:0] SSC_ADDR_PLL = 7'h04;
  localparam logic [6:0] SSC_ADDR_RUN = 7'h05;
  localparam int SSC_CLK_MHZ = 50;
  localparam int SSC_LOCK_US = 200;
  localparam int SSC_LOCK_CYC = SSC_LOCK_US * SSC_CLK_MHZ;
  localparam int SSC_GAP_US = 1;
  localparam int SSC_GAP_CYC = SSC_GAP_US * SSC_CLK_MHZ;
  localparam int SSC_CNT_W = 14;
  typedef enum logic [4:0] {
    SSC_HARD = 5'b00001,
    SSC_SOFT = 5'b00010,
    SSC_LOCK = 5'b00100,
    SSC_IDLE = 5'b01000,
    SSC_EXPO = 5'b10000
  } ssc_state_e;
endpackage

// file: design/ssc_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module ssc_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta;

  // First stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// file: design/ssc_spi_slave.sv
// Sensor SPI configuration slave with banked registers and startup flow
`timescale 1ns/1ps
module ssc_spi_slave
  import ssc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic spi_clk_i,
  input wire logic serial_select_low_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  input wire logic exposure_request_pin_i,
  output logic pll_lock_o,
  output logic soft_reset_o,
  output logic idle_o,
  output logic exposure_o
);
  // Banked register storage; address zero lives outside the banks
  logic [SSC_DATA_W-1:0] regs [SSC_NBANK*SSC_NREG];
  logic [SSC_BANK_W-1:0] bank_sel;

  // Link side framing, on the serial clock
  logic [3:0] bit_cnt;
  logic hdr_done;
  logic is_write;
  logic [SSC_ADDR_W-1:0] addr;
  logic [SSC_DATA_W-1:0] sh_in;
  logic [SSC_DATA_W-1:0] sh_out;
  logic [2:0] dbit;
  logic wr_fire;
  logic [SSC_ADDR_W-1:0] wr_addr;
  logic [SSC_DATA_W-1:0] wr_data;
  logic rd_active;
  logic wr_tog;
  // A full byte exists once at least one data byte was shifted
  logic sh_in_valid;

  // How a frame moves through the link side:
  // Select high holds every framing flop in reset, so clock activity
  // outside a frame is ignored and a cut byte never reaches storage.
  // The first rising edge takes the direction bit.
  // The next seven rising edges shift the address in, high bit first.
  // From then on each rising edge shifts one data bit into sh_in.
  // The rising edge of the low data bit also steps the address, so
  // the stored address is one ahead when the falling edge arrives.
  // The falling edge that ends the low data bit commits a write.
  // Therefore every commit uses the address minus one.
  // For a read the same falling edge loads the next byte to return.
  // The first read byte is loaded on the falling edge after the
  // low address bit, when no data bit has been shifted yet.
  // sh_in_valid tells these two cases apart on the falling edge of a write; a read loads on both.
  // The address wraps from the top location back to zero, so a
  // burst that runs past the end lands on the bank selector.
  // Register storage is written in the link clock domain itself.
  // Only the startup controls need the core clock, and those cross
  // as a toggle plus a held address and data word.
  // The held word changes at most once per byte, which is far
  // slower than the two flop synchroniser and edge detector.
  // Storage is cleared only by the hard reset pin.
  // The soft reset control leaves storage and link logic alone.
  // The read data line is driven only while a read returns data.
  // Its enable falls at once, without a clock, when select rises.
  // A write burst keeps the enable low for the whole frame.
  // The serial clock must idle low between frames.
  // Any other idle level would add one falling edge at select low.
  // The bank selector at address zero lives outside the banks.
  // It is readable and writable whichever bank is active.
  // Bank bits above the selector width read back as zero.
  // Storage locations at address zero inside the banks are unused.
  // Lock is modelled as a fixed count of core clock cycles.
  // Lock drops on the next core clock edge after the lock enable bit is cleared.

  wire sel_n = serial_select_low_i;
  wire [SSC_ADDR_W-1:0] next_addr_hdr = {addr[5:0], spi_mosi_i};
  wire [SSC_DATA_W-1:0] next_sh_in = {sh_in[6:0], spi_mosi_i};
  wire byte_end = hdr_done && (dbit == SSC_LAST_BIT);
  wire [SSC_ADDR_W-1:0] rd_addr = hdr_done ? addr + 7'h01 : addr;

  function automatic [SSC_DATA_W-1:0] rd_reg(input [SSC_ADDR_W-1:0] a,
                                             input [SSC_BANK_W-1:0] b);
    rd_reg = (a == SSC_ADDR_BANK) ? {6'h00, b} : regs[{b, a}];
  endfunction

  // Rising edge: shift header and data in; select high resets framing
  always_ff @(posedge spi_clk_i or posedge sel_n) begin
    if (sel_n) begin
      bit_cnt <= 4'h0;
      hdr_done <= 1'b0;
      is_write <= 1'b0;
      addr <= 7'h00;
      sh_in <= 8'h00;
      dbit <= 3'h0;
    end else if (!hdr_done) begin
      bit_cnt <= bit_cnt + 4'h1;
      if (bit_cnt == 4'h0) begin
        is_write <= spi_mosi_i;
      end else begin
        addr <= next_addr_hdr;
      end
      if (bit_cnt == SSC_HDR_BITS - 4'h1) begin
        hdr_done <= 1'b1;
      end
    end else begin
      sh_in <= next_sh_in;
      dbit <= dbit + 3'h1;
      if (byte_end) begin
        addr <= addr + 7'h01;
      end
    end
  end

  // Falling edge: launch read data and shift it out
  always_ff @(negedge spi_clk_i or posedge sel_n) begin
    if (sel_n) begin
      rd_active <= 1'b0;
      sh_out <= 8'h00;
    end else begin
      if (!is_write && hdr_done && dbit == 3'h0) begin
        sh_out <= rd_reg(rd_addr - 7'h01, bank_sel);
        rd_active <= 1'b1;
      end else begin
        sh_out <= {sh_out[6:0], 1'b0};
      end
    end
  end

  // Commit marker: data bit zero completed when dbit wraps to zero
  always_ff @(negedge spi_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_tog <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
    end else if (!sel_n && is_write && hdr_done && dbit == 3'h0 &&
                 bit_cnt == SSC_HDR_BITS && sh_in_valid) begin
      wr_tog <= ~wr_tog;
      wr_addr <= addr - 7'h01;
      wr_data <= sh_in;
    end
  end

  // Mark that a complete data byte has been shifted in
  always_ff @(posedge spi_clk_i or posedge sel_n) begin
    if (sel_n) begin
      sh_in_valid <= 1'b0;
    end else if (byte_end) begin
      sh_in_valid <= 1'b1;
    end
  end

  // Output drive and enable come straight from flops
  always_ff @(negedge spi_clk_i or posedge sel_n) begin
    if (sel_n) begin
      spi_miso_o <= 1'b0;
      spi_miso_oe_o <= 1'b0;
    end else begin
      spi_miso_oe_o <= !is_write && hdr_done;
      spi_miso_o <= (!is_write && hdr_done && dbit == 3'h0) ?
                    rd_reg(rd_addr - 7'h01, bank_sel)
                    [SSC_DATA_W-1] : sh_out[SSC_DATA_W-2];
    end
  end

  // Register write in the link domain; bank selector at address zero
  always_ff @(negedge spi_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bank_sel <= 2'h0;
    end else if (!sel_n && is_write && hdr_done && dbit == 3'h0 &&
                 bit_cnt == SSC_HDR_BITS && sh_in_valid) begin
      if (addr - 7'h01 == SSC_ADDR_BANK) begin
        bank_sel <= sh_in[SSC_BANK_W-1:0];
      end
    end
  end

  // Banked storage holds values through soft reset
  always_ff @(negedge spi_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < SSC_NBANK * SSC_NREG; i++) begin
        regs[i] <= SSC_REG_RST;
      end
    end else if (!sel_n && is_write && hdr_done && dbit == 3'h0 &&
        bit_cnt == SSC_HDR_BITS && sh_in_valid &&
        addr - 7'h01 != SSC_ADDR_BANK) begin
      regs[{bank_sel, addr - 7'h01}] <= sh_in;
    end
  end

  // Core domain: write event crosses as a toggle
  logic tog_s;
  logic tog_d;
  logic exp_s;
  logic exp_d;
  ssc_sync u_sync_tog (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i(wr_tog),
    .q_o(tog_s)
  );
  ssc_sync u_sync_exp (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i(exposure_request_pin_i),
    .q_o(exp_s)
  );

  // Captured command bits, taken a few cycles after the toggle settles
  logic soft_n;
  logic pll_en;
  logic run_req;
  logic [SSC_CNT_W-1:0] cnt;
  ssc_state_e state;
  ssc_state_e next_state;
  wire wr_evt = tog_s ^ tog_d;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tog_d <= 1'b0;
      exp_d <= 1'b0;
      soft_n <= 1'b0;
      pll_en <= 1'b0;
      run_req <= 1'b0;
    end else begin
      tog_d <= tog_s;
      exp_d <= exp_s;
      run_req <= 1'b0;
      if (wr_evt && wr_addr == SSC_ADDR_SOFT) begin
        soft_n <= wr_data[SSC_SOFT_BIT];
        run_req <= wr_data[SSC_SOFT_BIT];
      end
      if (wr_evt && wr_addr == SSC_ADDR_PLL) begin
        pll_en <= wr_data[SSC_PLL_BIT];
      end
    end
  end

  // Startup state flow
  always_comb begin
    next_state = state;
    case (state)
      SSC_HARD: next_state = SSC_SOFT;
      SSC_SOFT: if (pll_lock_o && run_req) next_state = SSC_IDLE;
      SSC_IDLE: begin
        if (!soft_n) next_state = SSC_SOFT;
        else if (exp_s && !exp_d) next_state = SSC_EXPO;
      end
      SSC_EXPO: if (!soft_n) next_state = SSC_SOFT;
                else if (!exp_s) next_state = SSC_IDLE;
      default: next_state = SSC_HARD;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= SSC_HARD;
      cnt <= '0;
      pll_lock_o <= 1'b0;
      soft_reset_o <= 1'b1;
      idle_o <= 1'b0;
      exposure_o <= 1'b0;
    end else begin
      state <= next_state;
      if (!pll_en) begin
        cnt <= '0;
        pll_lock_o <= 1'b0;
      end else if (cnt == SSC_CNT_W'(SSC_LOCK_CYC - 1)) begin
        pll_lock_o <= 1'b1;
      end else begin
        cnt <= cnt + 1'b1;
      end
      soft_reset_o <= (next_state == SSC_SOFT) || (next_state == SSC_HARD);
      idle_o <= next_state == SSC_IDLE;
      exposure_o <= next_state == SSC_EXPO;
    end
  end
endmodule

// file: test/ssc_spi_slave_monitor.sv
// Checker of the SPI slave port behaviour
`timescale 1ns/1ps
module ssc_spi_slave_monitor (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic spi_clk_i,
  input wire logic serial_select_low_i,
  input wire logic spi_mosi_i,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe_o,
  input wire logic exposure_request_pin_i,
  input wire logic pll_lock_o,
  input wire logic soft_reset_o,
  input wire logic idle_o,
  input wire logic exposure_o
);
  logic [4:0] cnt;
  logic dir;
  // Count link rises in a frame and keep the direction bit
  always_ff @(posedge spi_clk_i or posedge serial_select_low_i) begin
    if (serial_select_low_i) begin
      cnt <= 5'h00;
      dir <= 1'b0;
    end else begin
      if (cnt == 5'h00) dir <= spi_mosi_i;
      if (cnt != 5'h1f) cnt <= cnt + 5'h01;
    end
  end
  hdr_quiet_a: assert property (
    @(posedge spi_clk_i) disable iff (!rst_n_i)
    cnt < 5'h08 |-> !spi_miso_oe_o) else $error("miso driven in header");
  rd_drive_a: assert property (
    @(posedge spi_clk_i) disable iff (!rst_n_i)
    cnt >= 5'h08 && !dir |-> spi_miso_oe_o) else $error("read not driven");
  wr_quiet_a: assert property (
    @(posedge spi_clk_i) disable iff (!rst_n_i)
    cnt > 5'h00 && dir |-> !spi_miso_oe_o) else $error("write drives miso");
  sel_quiet_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    serial_select_low_i |-> !spi_miso_oe_o) else $error("miso not released");
  boot_soft_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> soft_reset_o && !idle_o) else $error("no soft reset");
  idle_lock_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(idle_o) |-> pll_lock_o && !soft_reset_o) else $error("early idle");
  expo_idle_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(exposure_o) |-> $past(idle_o)) else $error("exposure not idle");
  expo_req_a: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !exposure_request_pin_i [*6] |-> !exposure_o) else $error("stray expo");
endmodule
bind ssc_spi_slave ssc_spi_slave_monitor ssc_spi_slave_monitor_inst (.*);

// file: test/ssc_spi_master.sv
// Behavioural SPI master driving the sensor link
`timescale 1ns/1ps
module ssc_spi_master (
  output logic sck_o,
  output logic sel_n_o,
  output logic mosi_o,
  input wire logic miso_i,
  input wire logic miso_oe_i
);
  logic [7:0] tx [$];
  logic [7:0] rx [$];
  wire line = miso_oe_i ? miso_i : 1'bz;
  // Idle levels; the clock rests low outside frames except while noise toggles it
  initial begin
    sck_o = 1'b0;
    sel_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // One frame of nb bits: header, then bytes, MSB first
  task automatic xfer(input logic w, input logic [6:0] a, input int nb);
    logic [7:0] sh;
    logic [7:0] b;
    sh = {w, a};
    b = 8'h00;
    sel_n_o = 1'b0;
    for (int i = 0; i < nb; i++) begin
      mosi_o = sh[7];
      #7.5 sck_o = 1'b1;
      b = {b[6:0], line};
      sh = {sh[6:0], ~sh[7]};
      #7.5 sck_o = 1'b0;
      if (i % 8 == 7) begin
        if (i > 7) rx.push_back(b);
        sh = (w && tx.size() > 0) ? tx.pop_front() : ~b;
      end
    end
    #7.5 sel_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #7.5; // Keep select high a while before any next frame
  endtask
  // Clock and data toggling while deselected
  task automatic noise(input int n);
    repeat (n) begin
      #7.5 sck_o = ~sck_o;
      mosi_o = ~mosi_o;
    end
  endtask
endmodule

// file: test/tb_ssc_spi_slave.sv
// Self-checking bench for the sensor SPI configuration slave
`timescale 1ns/1ps
module tb_ssc_spi_slave import ssc_pkg::*; ;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic exposure_request_pin_i = 1'b0;
  logic spi_clk_i, serial_select_low_i, spi_mosi_i, spi_miso_o;
  logic spi_miso_oe_o, pll_lock_o, soft_reset_o, idle_o, exposure_o;
  logic [7:0] mem [4][128];
  logic [1:0] bk;
  logic [7:0] q [$];
  logic [6:0] ad;
  int bad_count = 0;
  int total_checks = 0;
  int n;
  wire [7:0] flags = {4'h0, spi_miso_oe_o, pll_lock_o, idle_o, soft_reset_o};
  always #10 mclk_i = ~mclk_i;
  ssc_spi_slave ssc_spi_slave_inst (.*);
  ssc_spi_master ssc_spi_master_inst (.sck_o(spi_clk_i),
    .sel_n_o(serial_select_low_i), .mosi_o(spi_mosi_i),
    .miso_i(spi_miso_o), .miso_oe_i(spi_miso_oe_o));
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic lim(input int c, input int m);
    if (c >= m) begin
      bad_count++;
      $display("wrong value wait expected done seen timeout");
      close_out();
    end
  endtask
  // Write q from address a; bytes cut short are not committed
  task automatic wr(input logic [6:0] a, input int nb);
    for (int k = 0; k < q.size(); k++) begin
      if (nb >= 16 + 8 * k) begin
        if (7'(a + k) == SSC_ADDR_BANK) bk = q[k][1:0];
        else mem[bk][7'(a + k)] = q[k];
      end
    end
    ssc_spi_master_inst.tx = q;
    ssc_spi_master_inst.xfer(1'b1, a, nb);
  endtask
  task automatic rd(input logic [6:0] a, input int c);
    ssc_spi_master_inst.rx.delete();
    ssc_spi_master_inst.xfer(1'b0, a, 8 + 8 * c);
    for (int k = 0; k < c; k++)
      chk("read", mem[bk][7'(a + k)], ssc_spi_master_inst.rx[k]);
  endtask
  initial begin
    void'($urandom(32'hd8b65085));
    for (int b = 0; b < 4; b++)
      for (int a = 0; a < 128; a++) mem[b][a] = SSC_REG_RST;
    bk = 2'h0;
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    chk("flags", 8'h01, flags);
    rd(7'h50, 2);
    for (int b = 0; b < 5; b++) begin
      q = '{8'(b % 4)};
      wr(SSC_ADDR_BANK, 16);
      ad = 7'(8 + $urandom % 112);
      q = '{8'($urandom), 8'($urandom), 8'($urandom)};
      wr(ad, 40);
      rd(ad, 3);
    end
    q = '{8'($urandom)};
    wr(ad, 15);
    ssc_spi_master_inst.noise(20);
    rd(ad, 1);
    q = '{8'($urandom), 8'h01};
    wr(7'h7f, 24);
    rd(7'h7f, 1);
    q = '{8'h00};
    wr(SSC_ADDR_BANK, 16);
    q = '{8'h01};
    wr(SSC_ADDR_PLL, 16);
    for (n = 0; n < SSC_LOCK_CYC + 16 && pll_lock_o !== 1'b1; n++)
      @(posedge mclk_i);
    lim(n, SSC_LOCK_CYC + 16);
    repeat (SSC_GAP_CYC) @(posedge mclk_i);
    q = '{8'h01};
    wr(SSC_ADDR_SOFT, 16);
    for (n = 0; n < 64 && idle_o !== 1'b1; n++) @(posedge mclk_i);
    lim(n, 64);
    #1;
    chk("flags", 8'h06, flags);
    rd(7'h7f, 1);
    repeat (SSC_GAP_CYC) @(posedge mclk_i);
    #1;
    chk("expo", 8'h00, {7'h0, exposure_o});
    @(posedge mclk_i);
    exposure_request_pin_i <= 1'b1;
    for (n = 0; n < 16 && exposure_o !== 1'b1; n++) @(posedge mclk_i);
    lim(n, 16);
    exposure_request_pin_i <= 1'b0;
    for (n = 0; n < 16 && exposure_o !== 1'b0; n++) @(posedge mclk_i);
    lim(n, 16);
    close_out();
  end
endmodule
